//--- bench/mpr_sva.sv
// Assertions on the link wires between the MAC end and the PHY end
`timescale 1ns/1ps
module mpr_sva
    import mpr_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic mclk,
    input wire logic pclk,
    input wire logic mac_line_o,
    input wire logic mac_line_oe,
    input wire logic phy_line_o,
    input wire logic phy_line_oe,
    input wire logic mac_data_oe,
    input wire logic phy_data_oe
);
    // All checks run on the system clock
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);

    a_line_one_driver: assert property (!(mac_line_oe && phy_line_oe))
        else $error("both ends drive the line");
    a_bus_one_driver: assert property (!(mac_data_oe && phy_data_oe))
        else $error("both ends drive the data bus");
    a_frame_start_bit: assert property ($rose(mac_line_oe) |-> mac_line_o == START_BIT)
        else $error("frame does not open with a start bit");
    a_mac_on_mclk: assert property (mac_line_oe && $past(mac_line_oe)
        && $changed(mac_line_o) |-> $rose(mclk)) else $error("line moved off link clock rise");
    a_phy_on_pclk: assert property (phy_line_oe && $past(phy_line_oe)
        && $changed(phy_line_o) |-> $rose(pclk)) else $error("reply moved off reply clock rise");
    a_reply_marker: assert property ($rose(phy_line_oe) |-> phy_line_o == MARK_BIT)
        else $error("reply does not open with a marker");
    a_turnaround_gap: assert property ($rose(phy_line_oe) |->
        !$past(mac_line_oe) && !$past(mac_line_oe, 8)) else $error("no turnaround gap");
    a_mclk_period: assert property ($rose(mclk) |=> (!$rose(mclk))[*7] ##1 $rose(mclk))
        else $error("link clock period is not eight cycles");
    a_bus_qualified: assert property (phy_data_oe |-> phy_line_oe)
        else $error("read byte driven without qualifier");

    // Main traffic kinds
    c_line_reply: cover property ($rose(phy_line_oe));
    c_bus_reply: cover property ($rose(phy_data_oe));
    c_bus_request: cover property ($rose(mac_data_oe));
endmodule

//--- bench/phy_register_mgmt_port_test.sv
// Self-checking bench joining the MAC end and the PHY end
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module phy_register_mgmt_port_test
    import mpr_pkg::*;
;
    logic             clk_sys_in    = 1'b0;
    logic             reset_in      = 1'b1;
    logic             stop_clock_in = 1'b0;
    logic             ce_phy        = 1'b1;
    logic             req_valid_in  = 1'b0;
    logic             req_write_in  = 1'b0;
    logic [7:0]       req_addr_in   = 8'h00;
    logic [7:0]       req_wdata_in  = 8'h00;
    mpr_phy_state_t   state_req_in  = PS_READY;
    logic             req_ready_out, rsp_valid_out, mac_par, cap_par, phy_par;
    logic [7:0]       rsp_rdata_out;
    logic [4:0]       pwr;
    mpr_phy_state_t   state_out;
    logic [31:0][7:0] dyn_regs_out;
    logic [31:0]      msh, psh;
    int               err_count = 0;
    int               checks    = 0;
    int               cyc       = 0;

    mpr_link_if lk();
    mpr_mac_end u_mpr_mac_end (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .ce_in(1'b1),
        .link(lk), .stop_clock_in(stop_clock_in), .req_valid_in(req_valid_in),
        .req_write_in(req_write_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
        .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
        .rsp_rdata_out(rsp_rdata_out), .parallel_mode_out(mac_par), .cap_parallel_out(cap_par));
    mpr_phy_end u_mpr_phy_end (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .ce_in(ce_phy),
        .link(lk), .state_req_in(state_req_in), .state_out(state_out),
        .radio_core_pwr_out(pwr[4]), .radio_tx_pwr_out(pwr[3]), .radio_rx_pwr_out(pwr[2]),
        .tx_path_en_out(pwr[1]), .rx_path_en_out(pwr[0]), .parallel_mode_out(phy_par),
        .dyn_regs_out(dyn_regs_out));
    mpr_sva u_mpr_sva (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .mclk(lk.mclk),
        .pclk(lk.pclk), .mac_line_o(lk.mac_line_o), .mac_line_oe(lk.mac_line_oe),
        .phy_line_o(lk.phy_line_o), .phy_line_oe(lk.phy_line_oe),
        .mac_data_oe(lk.mac_data_oe), .phy_data_oe(lk.phy_data_oe));

    // System clock, 8 ns
    initial begin
        forever #4 clk_sys_in = ~clk_sys_in;
    end

    // Line bits as each receiver samples them, on the falling link clock edges
    always @(negedge lk.mclk) if (lk.mac_line_oe) msh <= {msh[30:0], lk.mgmt_line};
    always @(negedge lk.pclk) if (lk.phy_line_oe) psh <= {psh[30:0], lk.mgmt_line};

    // Cuts a hung run short
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 30000) begin
            err_count++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // One register access through the MAC end, waiting for its answer
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge clk_sys_in);
        req_valid_in = 1'b1;
        req_write_in = w;
        req_addr_in  = a;
        req_wdata_in = d;
        @(negedge clk_sys_in);
        req_valid_in = 1'b0;
        `CHK("busy", 1'b0, req_ready_out)
        while (rsp_valid_out !== 1'b1 && n < 3000) begin
            @(negedge clk_sys_in);
            n++;
        end
        `CHK("answer", 1'b1, rsp_valid_out)
        `CHK("ready again", 1'b1, req_ready_out)
    endtask

    // Counts link clock changes over 64 system cycles
    task automatic pclk_edges(output int n);
        logic p;
        n = 0;
        p = lk.pclk;
        repeat (64) begin
            @(negedge clk_sys_in);
            if (lk.pclk !== p) n++;
            p = lk.pclk;
        end
    endtask

    // Serial traffic over all three regions, with the wire bits of the first access checked
    task automatic t_serial();
        logic [7:0] ad [4] = '{8'h05, 8'h1F, 8'h40, 8'h80};
        logic [7:0] wd [4] = '{8'hA5, 8'hC3, 8'h5A, 8'h3C};
        logic [7:0] rd [4] = '{8'hA5, 8'hC3, 8'h00, 8'h3C};
        `CHK("serial at start", 2'h0, {mac_par, phy_par})
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, ad[i], wd[i]);
            if (i == 0) `CHK("write bits", {START_BIT, ~READ_BIT, ad[0], wd[0]}, msh[17:0])
            xfer(1'b0, ad[i], 8'h00);
            `CHK("read value", rd[i], rsp_rdata_out)
            if (i == 0) `CHK("read request", {START_BIT, READ_BIT, ad[0]}, msh[9:0])
            if (i == 0) `CHK("reply bits", {MARK_BIT, rd[0]}, psh[8:0])
        end
        `CHK("reg 05", 8'hA5, dyn_regs_out[5])
        `CHK("reg 1F", 8'hC3, dyn_regs_out[31])
        $display("test serial done");
    endtask

    // Mode switch refused before the capability read, then parallel traffic
    task automatic t_parallel();
        xfer(1'b1, MODE_ADDR, 8'hFF);
        xfer(1'b0, MODE_ADDR, 8'h00);
        `CHK("mode refused", 8'h00, rsp_rdata_out)
        xfer(1'b0, CAP_MGMT_ADDR, 8'h00);
        `CHK("capability", 8'h01, rsp_rdata_out)
        `CHK("cap learned", 1'b1, cap_par)
        xfer(1'b1, MODE_ADDR, 8'hFF);
        `CHK("parallel on", 2'h3, {mac_par, phy_par})
        xfer(1'b0, MODE_ADDR, 8'h00);
        `CHK("reserved zero", 8'h01, rsp_rdata_out)
        xfer(1'b1, 8'h07, 8'h96);
        `CHK("reg 07", 8'h96, dyn_regs_out[7])
        xfer(1'b0, 8'h07, 8'h00);
        `CHK("parallel read", 8'h96, rsp_rdata_out)
        $display("test parallel done");
    endtask

    // Power decode and link clock in every operating state except reset
    task automatic t_states();
        logic [4:0] ex [1:5] = '{5'h00, 5'h00, 5'h10, 5'h1A, 5'h15};
        int n;
        for (int i = 1; i <= 5; i++) begin
            state_req_in = mpr_phy_state_t'(i);
            repeat (16) @(negedge clk_sys_in);
            `CHK("power", ex[i], pwr)
            pclk_edges(n);
            `CHK("pclk runs", i > 1, n > 0)
        end
        // Clock enable low freezes the PHY end, its link clock included
        ce_phy       = 1'b0;
        state_req_in = PS_SLEEP;
        pclk_edges(n);
        `CHK("frozen clock", 1'b1, n == 0)
        `CHK("frozen state", PS_RX, state_out)
        ce_phy        = 1'b1;
        stop_clock_in = 1'b1;
        state_req_in  = PS_STANDBY;
        repeat (16) @(negedge clk_sys_in);
        pclk_edges(n);
        `CHK("pclk stopped", 1'b1, n == 0)
        `CHK("standby", PS_STANDBY, state_out)
        stop_clock_in = 1'b0;
        state_req_in  = PS_RESET;
        repeat (4) @(negedge clk_sys_in);
        `CHK("defaults", 9'h000, {phy_par, dyn_regs_out[5]})
        $display("test states done");
    endtask

    // Main sequence
    initial begin
        repeat (20) @(negedge clk_sys_in);
        reset_in = 1'b0;
        t_serial();
        t_parallel();
        t_states();
        end_of_test();
    end
endmodule

//--- src/mpr_link_if.sv
// Link wires between the MAC end and the PHY end
`timescale 1ns/1ps
interface mpr_link_if;
    logic       mclk;
    logic       pclk;
    logic       clock_stop_req;
    logic       mac_line_o;
    logic       mac_line_oe;
    logic       phy_line_o;
    logic       phy_line_oe;
    logic [7:0] mac_data_o;
    logic       mac_data_oe;
    logic [7:0] phy_data_o;
    logic       phy_data_oe;
    logic       mgmt_line;
    logic [7:0] data_bus;

    // Wire levels; an undriven wire reads low
    assign mgmt_line = phy_line_oe ? phy_line_o : (mac_line_oe ? mac_line_o : 1'b0);
    assign data_bus  = phy_data_oe ? phy_data_o : (mac_data_oe ? mac_data_o : 8'h00);

    modport phy (input mclk, clock_stop_req, mgmt_line, data_bus,
                 output pclk, phy_line_o, phy_line_oe, phy_data_o, phy_data_oe);
    modport mac (input pclk, mgmt_line, data_bus,
                 output mclk, clock_stop_req, mac_line_o, mac_line_oe, mac_data_o,
                 mac_data_oe);
endinterface

//--- src/mpr_mac_end.sv
// MAC end: drives management frames over the link
`timescale 1ns/1ps
module mpr_mac_end
    import mpr_pkg::*;
(
    input  wire logic       clk_sys_in,
    input  wire logic       reset_in,
    input  wire logic       ce_in,
    mpr_link_if.mac         link,
    input  wire logic       stop_clock_in,
    input  wire logic       req_valid_in,
    input  wire logic       req_write_in,
    input  wire logic [7:0] req_addr_in,
    input  wire logic [7:0] req_wdata_in,
    output logic            req_ready_out,
    output logic            rsp_valid_out,
    output logic [7:0]      rsp_rdata_out,
    output logic            parallel_mode_out,
    output logic            cap_parallel_out
);
    typedef enum logic [2:0] {
        H_IDLE, H_START, H_CTRL, H_ADDR, H_WDATA, H_END, H_WAIT, H_RDATA
    } mpr_host_st_t;

    typedef struct packed {
        mpr_host_st_t    hs;
        logic [7:0]      div;
        logic            mclk;
        logic [2:0]      pclk_s;
        logic [1:0]      line_s;
        logic [1:0][7:0] data_s;
        logic            parallel;
        logic            cap_par;
        logic            rw;
        logic [2:0]      cnt;
        logic [7:0]      addr;
        logic [7:0]      wdata;
        logic [7:0]      shreg;
        logic            line_o;
        logic            line_oe;
        logic [7:0]      data_o;
        logic            data_oe;
        logic            rsp_valid;
        logic [7:0]      rdata;
        logic            stop;
    } mpr_mac_regs_t;

    mpr_mac_regs_t r;
    mpr_mac_regs_t next_r;
    logic          mrise;
    logic          pfall;

    // Next-state logic
    always_comb begin
        next_r           = r;
        next_r.rsp_valid = 1'b0;
        next_r.stop      = stop_clock_in;
        next_r.pclk_s    = {r.pclk_s[1:0], link.pclk};
        next_r.line_s    = {r.line_s[0], link.mgmt_line};
        next_r.data_s    = {r.data_s[0], link.data_bus};
        pfall            = r.pclk_s[2] & ~r.pclk_s[1];
        // Free-running forwarded clock from a divider
        mrise = 1'b0;
        if (r.div == HALF_M1) begin
            next_r.div  = 8'h00;
            next_r.mclk = ~r.mclk;
            mrise       = ~r.mclk;
        end else begin
            next_r.div = 8'(r.div + 8'h01);
        end
        case (r.hs)
            H_IDLE: begin
                if (req_valid_in) begin
                    next_r.rw    = ~req_write_in;
                    next_r.addr  = req_addr_in;
                    next_r.wdata = req_wdata_in;
                    if (req_addr_in == MODE_ADDR) begin
                        next_r.wdata = req_wdata_in & MODE_USED;
                        next_r.wdata[MODE_PAR_BIT] = req_wdata_in[MODE_PAR_BIT] & r.cap_par;
                    end
                    next_r.hs = H_START;
                end
            end
            H_START: begin
                if (mrise) begin
                    next_r.line_oe = 1'b1;
                    next_r.line_o  = START_BIT;
                    next_r.hs      = H_CTRL;
                end
            end
            H_CTRL: begin
                if (mrise) begin
                    next_r.line_o = r.rw ? READ_BIT : ~READ_BIT;
                    next_r.shreg  = r.addr;
                    next_r.cnt    = 3'h0;
                    if (r.parallel) begin
                        next_r.data_oe = 1'b1;
                        next_r.data_o  = r.addr;
                        next_r.hs      = r.rw ? H_END : H_WDATA;
                    end else begin
                        next_r.hs = H_ADDR;
                    end
                end
            end
            H_ADDR, H_WDATA: begin
                if (mrise) begin
                    next_r.line_o = r.parallel ? 1'b0 : r.shreg[7];
                    next_r.data_o = r.wdata;
                    next_r.shreg  = {r.shreg[6:0], 1'b0};
                    next_r.cnt    = 3'(r.cnt + 3'h1);
                    if ((r.hs == H_ADDR) && (r.cnt == LAST_BIT)) begin
                        next_r.shreg = r.wdata;
                        next_r.cnt   = 3'h0;
                        next_r.hs    = r.rw ? H_END : H_WDATA;
                    end else if ((r.hs == H_WDATA) && (r.parallel || (r.cnt == LAST_BIT))) begin
                        next_r.hs = H_END;
                    end
                end
            end
            H_END: begin
                // Release the wires; writes finish here
                if (mrise) begin
                    next_r.line_oe = 1'b0;
                    next_r.data_oe = 1'b0;
                    if (r.rw) begin
                        next_r.hs = H_WAIT;
                    end else begin
                        if (r.addr == MODE_ADDR) begin
                            next_r.parallel = r.wdata[MODE_PAR_BIT];
                        end
                        next_r.rsp_valid = 1'b1;
                        next_r.hs        = H_IDLE;
                    end
                end
            end
            H_WAIT: begin
                if (pfall && (r.line_s[1] == MARK_BIT)) begin
                    next_r.cnt = 3'h0;
                    if (r.parallel) begin
                        next_r.rdata     = r.data_s[1];
                        next_r.rsp_valid = 1'b1;
                        next_r.hs        = H_IDLE;
                    end else begin
                        next_r.hs = H_RDATA;
                    end
                end
            end
            H_RDATA: begin
                if (pfall) begin
                    next_r.shreg = {r.shreg[6:0], r.line_s[1]};
                    next_r.cnt   = 3'(r.cnt + 3'h1);
                    if (r.cnt == LAST_BIT) begin
                        next_r.rdata     = {r.shreg[6:0], r.line_s[1]};
                        next_r.rsp_valid = 1'b1;
                        next_r.hs        = H_IDLE;
                    end
                end
            end
            default: begin
                next_r.hs = H_IDLE;
            end
        endcase
        // Learn parallel capability from any read of it
        if (next_r.rsp_valid && r.rw && (r.addr == CAP_MGMT_ADDR)) begin
            next_r.cap_par = next_r.rdata[CAP_PAR_BIT];
        end
    end

    // State register with clock enable
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            r <= '0;
        end else if (ce_in) begin
            r <= next_r;
        end
    end

    assign link.mclk           = r.mclk;
    assign link.clock_stop_req = r.stop;
    assign link.mac_line_o     = r.line_o;
    assign link.mac_line_oe    = r.line_oe;
    assign link.mac_data_o     = r.data_o;
    assign link.mac_data_oe    = r.data_oe;
    assign req_ready_out       = (r.hs == H_IDLE);
    assign rsp_valid_out       = r.rsp_valid;
    assign rsp_rdata_out       = r.rdata;
    assign parallel_mode_out   = r.parallel;
    assign cap_parallel_out    = r.cap_par;
endmodule

//--- src/mpr_phy_end.sv
// PHY end: register space, operational states and management line slave
`timescale 1ns/1ps
// Behaviour
// - Port starts in serial mode after reset
// - MAC enables parallel only when capability allows
// - Serial access starts with control, then address
// - Serial write data follows address bit by bit
// - Serial read: PHY shifts register out on line
// - Parallel: control on line, address/data on bus; read byte not driven in transmit or receive
// - Parallel read: PHY line qualifies driven byte
// - MAC changes line on its clock rising edges
// - PHY drives read data on its clock rises
// - Reset state restores defaults; clock undefined
// - Sleep: radio off, no interface clock
// - Standby: radio off, clock runs unless stopped
// - Ready: radio partly on, clock runs
// - Transmit: transmit paths active, clock runs
// - Receive: receive paths active, clock runs
// - Run-time parameters live in real registers
// - Reserved bits read ignored, written zero
// - Eight-bit address selects 256 byte registers
// - Regions: run-time, capability, vendor upper half
// - Capability values fixed, never change
// - Idle data bus direction follows port mode; both ends release the bus when idle, in either mode
module mpr_phy_end
    import mpr_pkg::*;
#(
    parameter bit PARALLEL_OK = 1'b1
) (
    input  wire logic           clk_sys_in,
    input  wire logic           reset_in,
    input  wire logic           ce_in,
    mpr_link_if.phy             link,
    input  wire mpr_phy_state_t state_req_in,
    output mpr_phy_state_t      state_out,
    output logic                radio_core_pwr_out,
    output logic                radio_tx_pwr_out,
    output logic                radio_rx_pwr_out,
    output logic                tx_path_en_out,
    output logic                rx_path_en_out,
    output logic                parallel_mode_out,
    output logic [31:0][7:0]    dyn_regs_out
);
    typedef enum logic [2:0] {
        M_IDLE, M_CTRL, M_ADDR, M_WDATA, M_TURN, M_RDATA, M_REL
    } mpr_mgmt_st_t;

    typedef struct packed {
        mpr_phy_state_t   st;
        mpr_mgmt_st_t     ms;
        logic [2:0]       mclk_s;
        logic [1:0]       line_s;
        logic [1:0][7:0]  data_s;
        logic [1:0]       stop_s;
        logic [7:0]       div;
        logic             pclk;
        logic             parallel;
        logic             rw;
        logic [2:0]       bit_cnt;
        logic [7:0]       addr;
        logic [7:0]       shreg;
        logic             line_o;
        logic             line_oe;
        logic [7:0]       data_o;
        logic             data_oe;
        logic [31:0][7:0] dyn;
        logic [127:0][7:0] vend;
    } mpr_phy_regs_t;

    mpr_phy_regs_t r;
    mpr_phy_regs_t next_r;

    // Fixed capability byte; never written
    function automatic logic [7:0] cap_byte(input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == CAP_MGMT_ADDR) begin
            v[CAP_PAR_BIT] = PARALLEL_OK;
        end
        return v;
    endfunction

    // Read decode over the three regions
    function automatic logic [7:0] rd_byte(input mpr_phy_regs_t s, input logic [7:0] a);
        logic [7:0] v;
        if (a <= DYN_LAST) begin
            v = s.dyn[a[4:0]];
        end else if (a <= CAP_LAST) begin
            v = cap_byte(a);
        end else begin
            v = s.vend[a[6:0]];
        end
        return v;
    endfunction

    logic       mfall;
    logic       prise;
    logic       clk_on;
    logic       wr_en;
    logic [7:0] wr_val;
    logic       bus_free;

    // Next-state logic
    always_comb begin
        next_r = r;
        wr_en  = 1'b0;
        wr_val = 8'h00;
        // Two-stage synchronisers for all link inputs
        next_r.mclk_s = {r.mclk_s[1:0], link.mclk};
        next_r.line_s = {r.line_s[0], link.mgmt_line};
        next_r.data_s = {r.data_s[0], link.data_bus};
        next_r.stop_s = {r.stop_s[0], link.clock_stop_req};
        // MAC changes on rise, so sample at its fall
        mfall = r.mclk_s[2] & ~r.mclk_s[1];
        next_r.st = state_req_in;
        // Interface clock gating by state
        clk_on = (r.st == PS_READY) || (r.st == PS_TX) || (r.st == PS_RX)
            || ((r.st == PS_STANDBY) && !r.stop_s[1]);
        bus_free = (r.st != PS_TX) && (r.st != PS_RX);
        prise = 1'b0;
        if (!clk_on) begin
            next_r.pclk = 1'b0;
            next_r.div  = 8'h00;
        end else if (r.div == HALF_M1) begin
            next_r.div  = 8'h00;
            next_r.pclk = ~r.pclk;
            prise       = ~r.pclk;
        end else begin
            next_r.div = 8'(r.div + 8'h01);
        end
        // Management frame engine
        case (r.ms)
            M_IDLE: begin
                next_r.line_oe = 1'b0;
                next_r.data_oe = 1'b0;
                if (mfall && (r.line_s[1] == START_BIT)) begin
                    next_r.ms = M_CTRL;
                end
            end
            M_CTRL: begin
                if (mfall) begin
                    next_r.rw      = (r.line_s[1] == READ_BIT);
                    next_r.bit_cnt = 3'h0;
                    if (r.parallel) begin
                        next_r.addr = r.data_s[1];
                        next_r.ms   = (r.line_s[1] == READ_BIT) ? M_TURN : M_WDATA;
                    end else begin
                        next_r.ms = M_ADDR;
                    end
                end
            end
            M_ADDR: begin
                if (mfall) begin
                    next_r.addr    = {r.addr[6:0], r.line_s[1]};
                    next_r.bit_cnt = 3'(r.bit_cnt + 3'h1);
                    if (r.bit_cnt == LAST_BIT) begin
                        next_r.bit_cnt = 3'h0;
                        next_r.ms      = r.rw ? M_TURN : M_WDATA;
                    end
                end
            end
            M_WDATA: begin
                if (mfall) begin
                    next_r.shreg   = {r.shreg[6:0], r.line_s[1]};
                    next_r.bit_cnt = 3'(r.bit_cnt + 3'h1);
                    if (r.parallel) begin
                        wr_en     = 1'b1;
                        wr_val    = r.data_s[1];
                        next_r.ms = M_IDLE;
                    end else if (r.bit_cnt == LAST_BIT) begin
                        wr_en     = 1'b1;
                        wr_val    = {r.shreg[6:0], r.line_s[1]};
                        next_r.ms = M_IDLE;
                    end
                end
            end
            M_TURN: begin
                // One idle interface clock, then a marker cycle
                if (prise) begin
                    if (r.bit_cnt == 3'h0) begin
                        next_r.bit_cnt = 3'h1;
                    end else begin
                        next_r.line_oe = 1'b1;
                        next_r.line_o  = MARK_BIT;
                        next_r.shreg   = rd_byte(r, r.addr);
                        next_r.data_o  = rd_byte(r, r.addr);
                        next_r.data_oe = r.parallel && bus_free;
                        next_r.bit_cnt = 3'h0;
                        next_r.ms      = M_RDATA;
                    end
                end
            end
            M_RDATA: begin
                if (prise) begin
                    if (r.parallel) begin
                        next_r.line_oe = 1'b0;
                        next_r.data_oe = 1'b0;
                        next_r.ms      = M_IDLE;
                    end else begin
                        next_r.line_o  = r.shreg[7];
                        next_r.shreg   = {r.shreg[6:0], 1'b0};
                        next_r.bit_cnt = 3'(r.bit_cnt + 3'h1);
                        if (r.bit_cnt == LAST_BIT) begin
                            next_r.ms = M_REL;
                        end
                    end
                end
            end
            M_REL: begin
                if (prise) begin
                    next_r.line_oe = 1'b0;
                    next_r.ms      = M_IDLE;
                end
            end
            default: begin
                next_r.ms = M_IDLE;
            end
        endcase
        // Register write; capability region ignores writes
        if (wr_en) begin
            if (r.addr == MODE_ADDR) begin
                next_r.dyn[0] = wr_val & MODE_USED;
                next_r.dyn[0][MODE_PAR_BIT] = wr_val[MODE_PAR_BIT] & PARALLEL_OK;
                next_r.parallel = wr_val[MODE_PAR_BIT] & PARALLEL_OK;
            end else if (r.addr <= DYN_LAST) begin
                next_r.dyn[r.addr[4:0]] = wr_val;
            end else if (r.addr > CAP_LAST) begin
                next_r.vend[r.addr[6:0]] = wr_val;
            end
        end
        // Reset state returns configuration to defaults
        if (r.st == PS_RESET) begin
            next_r.dyn      = {32{DYN_RESET}};
            next_r.parallel = 1'b0;
            next_r.ms       = M_IDLE;
            next_r.line_oe  = 1'b0;
            next_r.data_oe  = 1'b0;
        end
    end

    // State register with clock enable
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            r <= '0;
        end else if (ce_in) begin
            r <= next_r;
        end
    end

    // Link and user-side outputs
    assign link.pclk          = r.pclk;
    assign link.phy_line_o    = r.line_o;
    assign link.phy_line_oe   = r.line_oe;
    assign link.phy_data_o    = r.data_o;
    assign link.phy_data_oe   = r.data_oe;
    assign state_out          = r.st;
    assign radio_core_pwr_out = (r.st == PS_READY) || (r.st == PS_TX) || (r.st == PS_RX);
    assign radio_tx_pwr_out   = (r.st == PS_TX);
    assign radio_rx_pwr_out   = (r.st == PS_RX);
    assign tx_path_en_out     = (r.st == PS_TX);
    assign rx_path_en_out     = (r.st == PS_RX);
    assign parallel_mode_out  = r.parallel;
    assign dyn_regs_out       = r.dyn;
endmodule

//--- src/mpr_pkg.sv
// Shared constants and types of the register management port
package mpr_pkg;
    // Register space layout
    localparam logic [7:0] DYN_LAST      = 8'h1F;
    localparam logic [7:0] CAP_LAST      = 8'h7F;
    localparam logic [7:0] MODE_ADDR     = 8'h00;
    localparam logic [7:0] CAP_MGMT_ADDR = 8'h20;
    localparam int         MODE_PAR_BIT  = 0;
    localparam int         CAP_PAR_BIT   = 0;
    localparam logic [7:0] MODE_USED     = 8'h01;
    localparam logic [7:0] DYN_RESET     = 8'h00;
    // Frame coding
    localparam logic       START_BIT     = 1'b1;
    localparam logic       READ_BIT      = 1'b1;
    localparam logic       MARK_BIT      = 1'b1;
    localparam logic [2:0] LAST_BIT      = 3'h7;
    // Link clock timing
    localparam int         SYS_PERIOD_NS  = 8;
    localparam int         LINK_PERIOD_NS = 64;
    localparam int         HALF_CYC = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);
    localparam logic [7:0] HALF_M1  = 8'(HALF_CYC - 1);
    // Operational states of the PHY
    typedef enum logic [2:0] {
        PS_RESET, PS_SLEEP, PS_STANDBY, PS_READY, PS_TX, PS_RX
    } mpr_phy_state_t;
endpackage
